// ### logic/smdc_pkg.sv
// Package with the strap-mode default configuration constants and carrier types.
package smdc_pkg;

  // Serial-to-Ethernet connection default, serial 1 bridged to Ethernet 1.
  localparam logic [7:0] BRIDGE_DEFAULT = 8'h01;
  // Transmit line configuration default, rising-edge launch, enable input ignored.
  localparam logic [7:0] TX_LINE_CFG_DEFAULT = 8'h00;
  // Serial reset and power-down default, everything powered and running.
  localparam logic [7:0] LINE_RSTPD_DEFAULT = 8'h00;
  // Transmit frame check control, 16-bit check sequence selected.
  localparam logic [7:0] TX_FCS_CTRL_DEFAULT = 8'h10;
  // Interframe fill count, one octet.
  localparam logic [7:0] TX_FILL_COUNT_DEFAULT = 8'h01;
  // Interframe fill octet value.
  localparam logic [7:0] FILL_OCTET = 8'h7e;
  // Receive frame check control, 16-bit check sequence selected.
  localparam logic [7:0] RX_FCS_CTRL_BASE = 8'h10;
  // Field positions inside the receive frame check control word for strap-driven bits.
  localparam int RX_DESCR_BYPASS_BIT = 0;
  localparam int RX_BIT_REVERSE_BIT = 1;
  // Longest frame accepted on both sides, in bytes, without the check sequence.
  localparam logic [15:0] MAX_FRAME_BYTES = 16'h07e0;
  // Receive line configuration default, falling-edge sample, gapped clock allowed.
  localparam logic [7:0] RX_LINE_CFG_DEFAULT = 8'h00;
  // Resend on every error class.
  localparam logic [7:0] TX_RESEND_DEFAULT = 8'h00;
  // Reject broadcast, control and errored frames.
  localparam logic [7:0] RX_REJECT_DEFAULT = 8'h00;
  // MAC control word default.
  localparam logic [31:0] MAC_CONTROL_DEFAULT = 32'h0014000c;
  // MAC flow control word default with the pause time in the upper half.
  localparam logic [31:0] MAC_PAUSE_DEFAULT = 32'h01400000;
  // Bit of the MAC flow control word that enables flow control.
  localparam int MAC_FLOW_ENABLE_BIT = 0;
  // Pause time in slot times.
  localparam logic [15:0] PAUSE_SLOTS = 16'h0140;

  // Profile codes on the profile strap pins.
  localparam logic [1:0] PROFILE_LOW_RATE = 2'h0;
  localparam logic [1:0] PROFILE_HIGH_RATE = 2'h2;

  // Queue defaults for the low-rate profile.
  localparam logic [7:0] TXQ_SIZE_LOW = 8'h14;
  localparam logic [7:0] RXQ_SIZE_LOW = 8'h2c;
  localparam logic [7:0] RXQ_LOW_MARK_LOW = 8'h0f;
  localparam logic [7:0] RXQ_HIGH_MARK_LOW = 8'h1e;
  // Queue defaults for the high-rate profile.
  localparam logic [7:0] TXQ_SIZE_HIGH = 8'h18;
  localparam logic [7:0] RXQ_SIZE_HIGH = 8'h28;
  localparam logic [7:0] RXQ_LOW_MARK_HIGH = 8'h0c;
  localparam logic [7:0] RXQ_HIGH_MARK_HIGH = 8'h18;
  // Transmit watermarks, common to both profiles.
  localparam logic [7:0] TXQ_HIGH_MARK = 8'h0c;
  localparam logic [7:0] TXQ_LOW_MARK = 8'h06;
  // Buffers per code step and bytes per buffer.
  localparam int BUFFERS_PER_CODE = 32;
  localparam int BYTES_PER_BUFFER = 2048;

  // Cycles the datapaths are held in reset after the defaults are loaded.
  localparam logic [3:0] HOLD_CYCLES = 4'h4;

  // Strap pins after synchronisation.
  typedef struct packed {
    logic       mode_select;
    logic [1:0] profile;
    logic       auto_flow;
    logic       bit_order;
    logic       scram_bypass;
    logic       laps_framing;
  } smdc_straps_t;

  // Serial line configuration words.
  typedef struct packed {
    logic [7:0]  port_bridge_select;
    logic [7:0]  tx_line_config;
    logic [7:0]  line_reset_powerdown;
    logic [7:0]  tx_frame_check_control;
    logic [7:0]  tx_fill_gap_count;
    logic [7:0]  rx_frame_check_control;
    logic [15:0] rx_line_max_length;
    logic [7:0]  rx_line_config;
  } smdc_line_cfg_t;

  // Ethernet side configuration words.
  typedef struct packed {
    logic [7:0]  tx_resend_criteria;
    logic [7:0]  rx_reject_control;
    logic [7:0]  mac_rx_max_size_high;
    logic [7:0]  mac_rx_max_size_low;
    logic [31:0] mac_control_word;
    logic [31:0] mac_pause_control;
  } smdc_mac_cfg_t;

  // Queue arbiter configuration codes.
  typedef struct packed {
    logic [7:0] tx_queue_size;
    logic [7:0] tx_queue_high_mark;
    logic [7:0] tx_queue_low_mark;
    logic [7:0] rx_queue_size;
    logic [7:0] rx_queue_low_mark;
    logic [7:0] rx_queue_high_mark;
  } smdc_queue_cfg_t;

endpackage

// ### logic/smdc_strap_sync.sv
// Two-flip-flop synchroniser bank for the strap pins.
`timescale 1ns/1ps
`default_nettype none
module smdc_strap_sync #(
  parameter int WIDTH = 7
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // First stage; read only by the second stage.
  logic [WIDTH-1:0] meta_reg;

  // Both stages clear to zero so nothing unknown leaves the bank.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // smdc_strap_sync
`default_nettype wire

// ### logic/smdc_loader.sv
// Strap-mode default configuration loader.
//
// What this block does
// - Bridge select defaults to serial 1 Ethernet 1.
// - Transmit data launches on rising line clock.
// - Line reset and power-down default all zeros.
// - Transmitter appends a 16-bit check sequence.
// - One 7E fill octet between frames.
// - Receiver checks 16-bit FCS; straps steer descrambling.
// - Serial receiver drops frames over 2016 bytes.
// - Receive samples on falling edge, gaps tolerated.
// - MAC resends frames after any error class.
// - Drop broadcast, control and errored Ethernet frames.
// - MAC receive max size 2016 bytes.
// - Flow strap enables flow control, pause 320.
// - Transmit queue size follows the profile straps.
// - Transmit high mark code 0c both profiles.
// - Transmit low mark code 06 both profiles.
// - Receive queue size follows the profile straps.
// - Receive low mark follows the profile straps.
// - Receive high mark follows the profile straps.
// - Each buffer unit is 2048 bytes.
// - Defaults apply only if mode strap is high when sampled after reset.
// - Bit-order strap: 0 MSB first, 1 LSB first.
// - Scrambler strap bypasses; framing strap enables framing.
`timescale 1ns/1ps
`default_nettype none
module smdc_loader (
  input  wire logic                    clk,                  // System clock, 100 MHz.
  input  wire logic                    resetn,               // Asynchronous reset, active low.
  input  wire logic                    strap_mode_select,    // Hardware-mode strap pin.
  input  wire logic [1:0]              profile_strap,        // Line-rate profile strap pins.
  input  wire logic                    auto_flow_strap,      // Automatic flow-control strap.
  input  wire logic                    bit_order_strap,      // 1 selects LSB first.
  input  wire logic                    scrambler_bypass_strap, // 1 bypasses the scrambler.
  input  wire logic                    laps_framing_strap,   // 1 enables X.86 framing.
  input  wire logic                    sw_cfg_valid,         // Software or EEPROM words are valid.
  input  wire smdc_pkg::smdc_line_cfg_t  sw_line_cfg,        // Software line configuration.
  input  wire smdc_pkg::smdc_mac_cfg_t   sw_mac_cfg,         // Software MAC configuration.
  input  wire smdc_pkg::smdc_queue_cfg_t sw_queue_cfg,       // Software queue configuration.
  output smdc_pkg::smdc_line_cfg_t     line_cfg,             // Applied line configuration.
  output smdc_pkg::smdc_mac_cfg_t      mac_cfg,              // Applied MAC configuration.
  output smdc_pkg::smdc_queue_cfg_t    queue_cfg,            // Applied queue configuration.
  output logic                         strap_mode_active,    // Strap defaults are in force.
  output logic                         tx_bit_lsb_first,     // Transmit bit order.
  output logic                         rx_bit_lsb_first,     // Receive bit order.
  output logic                         scrambler_enable,     // Transmit scrambler on.
  output logic                         descrambler_enable,   // Receive descrambler on.
  output logic                         laps_framing_enable,  // X.86 framing both directions.
  output logic                         flow_control_enable,  // MAC flow control on.
  output logic                         profile_invalid,      // Profile straps not a defined code.
  output logic                         datapath_resetn,      // Datapath reset release, active low.
  output logic                         cfg_done              // Configuration is loaded.
);

  // Loader sequence states.
  typedef enum logic [3:0] {
    SMDC_IDLE   = 4'b0001,
    SMDC_SAMPLE = 4'b0010,
    SMDC_LOAD   = 4'b0100,
    SMDC_RUN    = 4'b1000
  } smdc_state_t;

  smdc_state_t             state_reg;    // Current sequence state.
  smdc_state_t             state_next;   // Next sequence state.
  smdc_pkg::smdc_straps_t  straps_sync;  // Synchronised strap pins.
  smdc_pkg::smdc_straps_t  straps_reg;   // Straps captured once after reset.
  logic [3:0]              hold_reg;     // Cycles left before datapath release.
  logic                    settle_reg;   // Synchroniser has filled once after reset.

  // Strap pins come from the board, so they cross into the clock domain first.
  smdc_strap_sync #(
    .WIDTH ($bits(smdc_pkg::smdc_straps_t))
  ) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({strap_mode_select, profile_strap, auto_flow_strap,
                bit_order_strap, scrambler_bypass_strap, laps_framing_strap}),
    .sync_out (straps_sync)
  );

  // Profile decode, shared by the four profile-dependent queue words; unknown codes fall back to the low-rate set.
  function automatic logic profile_is_high(input logic [1:0] p);
    profile_is_high = (p == smdc_pkg::PROFILE_HIGH_RATE);
  endfunction

  // Sequence: wait two cycles for the synchroniser to fill, sample, load, then release.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SMDC_IDLE: begin
        if (settle_reg) begin
          state_next = SMDC_SAMPLE;
        end
      end
      SMDC_SAMPLE: state_next = SMDC_LOAD;
      SMDC_LOAD: begin
        if (hold_reg == 4'h0) begin
          state_next = SMDC_RUN;
        end
      end
      SMDC_RUN:    state_next = SMDC_RUN;
      default:     state_next = SMDC_IDLE;
    endcase
  end

  // One extra idle cycle lets the synchroniser show the real pin levels.
  // Sampling any earlier would capture the zeros the bank holds through reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settle_reg <= 1'b0;
    end else if (state_reg == SMDC_IDLE) begin
      settle_reg <= 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= SMDC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Straps are taken once; later pin wiggles are ignored until the next reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      straps_reg <= '0;
    end else if (state_reg == SMDC_SAMPLE) begin
      straps_reg <= straps_sync;
    end
  end

  // Hold counter keeps the datapaths in reset while the words settle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_reg <= smdc_pkg::HOLD_CYCLES;
    end else if (state_reg == SMDC_LOAD && hold_reg != 4'h0) begin
      hold_reg <= hold_reg - 4'h1;
    end
  end

  // Line configuration words; in strap mode the fixed defaults, else software.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_cfg <= '0;
    end else if (state_reg == SMDC_LOAD) begin
      if (straps_reg.mode_select) begin
        line_cfg.port_bridge_select     <= smdc_pkg::BRIDGE_DEFAULT;
        line_cfg.tx_line_config         <= smdc_pkg::TX_LINE_CFG_DEFAULT;
        line_cfg.line_reset_powerdown   <= smdc_pkg::LINE_RSTPD_DEFAULT;
        line_cfg.tx_frame_check_control <= smdc_pkg::TX_FCS_CTRL_DEFAULT;
        line_cfg.tx_fill_gap_count      <= smdc_pkg::TX_FILL_COUNT_DEFAULT;
        // The check-sequence width is fixed; descrambling and bit order mirror the straps.
        line_cfg.rx_frame_check_control <= smdc_pkg::RX_FCS_CTRL_BASE
          | (8'(straps_reg.scram_bypass) << smdc_pkg::RX_DESCR_BYPASS_BIT)
          | (8'(straps_reg.bit_order) << smdc_pkg::RX_BIT_REVERSE_BIT);
        line_cfg.rx_line_max_length     <= smdc_pkg::MAX_FRAME_BYTES;
        line_cfg.rx_line_config         <= smdc_pkg::RX_LINE_CFG_DEFAULT;
      end else if (sw_cfg_valid) begin
        line_cfg <= sw_line_cfg;
      end
    end else if (state_reg == SMDC_RUN && !straps_reg.mode_select && sw_cfg_valid) begin
      // Software mode keeps following the processor after start-up.
      line_cfg <= sw_line_cfg;
    end
  end

  // MAC configuration words.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mac_cfg <= '0;
    end else if (state_reg == SMDC_LOAD && straps_reg.mode_select) begin
      mac_cfg.tx_resend_criteria   <= smdc_pkg::TX_RESEND_DEFAULT;
      mac_cfg.rx_reject_control    <= smdc_pkg::RX_REJECT_DEFAULT;
      mac_cfg.mac_rx_max_size_high <= smdc_pkg::MAX_FRAME_BYTES[15:8];
      mac_cfg.mac_rx_max_size_low  <= smdc_pkg::MAX_FRAME_BYTES[7:0];
      mac_cfg.mac_control_word     <= smdc_pkg::MAC_CONTROL_DEFAULT;
      // Flow-control enable bit follows the strap; the pause time is fixed.
      mac_cfg.mac_pause_control    <= smdc_pkg::MAC_PAUSE_DEFAULT
        | (32'(straps_reg.auto_flow) << smdc_pkg::MAC_FLOW_ENABLE_BIT);
    end else if ((state_reg == SMDC_LOAD || state_reg == SMDC_RUN)
                 && !straps_reg.mode_select && sw_cfg_valid) begin
      mac_cfg <= sw_mac_cfg;
    end
  end

  // Queue codes; each code step counts 32 buffers of 2048 bytes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      queue_cfg <= '0;
    end else if (state_reg == SMDC_LOAD && straps_reg.mode_select) begin
      queue_cfg.tx_queue_high_mark <= smdc_pkg::TXQ_HIGH_MARK;
      queue_cfg.tx_queue_low_mark  <= smdc_pkg::TXQ_LOW_MARK;
      if (profile_is_high(straps_reg.profile)) begin
        queue_cfg.tx_queue_size      <= smdc_pkg::TXQ_SIZE_HIGH;
        queue_cfg.rx_queue_size      <= smdc_pkg::RXQ_SIZE_HIGH;
        queue_cfg.rx_queue_low_mark  <= smdc_pkg::RXQ_LOW_MARK_HIGH;
        queue_cfg.rx_queue_high_mark <= smdc_pkg::RXQ_HIGH_MARK_HIGH;
      end else begin
        queue_cfg.tx_queue_size      <= smdc_pkg::TXQ_SIZE_LOW;
        queue_cfg.rx_queue_size      <= smdc_pkg::RXQ_SIZE_LOW;
        queue_cfg.rx_queue_low_mark  <= smdc_pkg::RXQ_LOW_MARK_LOW;
        queue_cfg.rx_queue_high_mark <= smdc_pkg::RXQ_HIGH_MARK_LOW;
      end
    end else if ((state_reg == SMDC_LOAD || state_reg == SMDC_RUN)
                 && !straps_reg.mode_select && sw_cfg_valid) begin
      queue_cfg <= sw_queue_cfg;
    end
  end

  // Feature enables, registered from the captured straps.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_mode_active   <= 1'b0;
      tx_bit_lsb_first    <= 1'b0;
      rx_bit_lsb_first    <= 1'b0;
      scrambler_enable    <= 1'b0;
      descrambler_enable  <= 1'b0;
      laps_framing_enable <= 1'b0;
      flow_control_enable <= 1'b0;
      profile_invalid     <= 1'b0;
    end else if (state_reg == SMDC_LOAD) begin
      strap_mode_active   <= straps_reg.mode_select;
      // Outside strap mode these follow software, so they rest at zero here.
      tx_bit_lsb_first    <= straps_reg.mode_select & straps_reg.bit_order;
      rx_bit_lsb_first    <= straps_reg.mode_select & straps_reg.bit_order;
      scrambler_enable    <= straps_reg.mode_select & ~straps_reg.scram_bypass;
      descrambler_enable  <= straps_reg.mode_select & ~straps_reg.scram_bypass;
      laps_framing_enable <= straps_reg.mode_select & straps_reg.laps_framing;
      flow_control_enable <= straps_reg.mode_select & straps_reg.auto_flow;
      // A profile code other than the two defined ones is flagged, low-rate set used.
      profile_invalid     <= straps_reg.mode_select
        & (straps_reg.profile != smdc_pkg::PROFILE_LOW_RATE)
        & (straps_reg.profile != smdc_pkg::PROFILE_HIGH_RATE);
    end
  end

  // Datapaths leave reset only after every word is loaded.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      datapath_resetn <= 1'b0;
      cfg_done        <= 1'b0;
    end else begin
      datapath_resetn <= (state_reg == SMDC_RUN);
      cfg_done        <= (state_reg == SMDC_RUN);
    end
  end

  // Assertions.
  a_release_after_load: assert property (@(posedge clk) disable iff (!resetn)
    $rose(datapath_resetn) |-> $past(state_reg) == SMDC_RUN)
    else $error("Datapath released before loading finished.");

  // Last hold cycle of the load state.
  sequence s_load_last;
    state_reg == SMDC_LOAD && hold_reg == 4'h0;
  endsequence

  // One cycle in run, then the datapaths leave reset.
  sequence s_run_release;
    state_reg == SMDC_RUN ##1 datapath_resetn;
  endsequence

  a_release_order: assert property (@(posedge clk) disable iff (!resetn)
    s_load_last |=> s_run_release)
    else $error("Datapath release does not follow the load.");

  a_straps_frozen: assert property (@(posedge clk) disable iff (!resetn)
    cfg_done |-> $stable(straps_reg))
    else $error("Captured straps moved after loading.");

  a_bridge_default: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_done && strap_mode_active) |-> line_cfg.port_bridge_select == 8'h01)
    else $error("Bridge select default wrong.");

  a_powerdown_clear: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_done && strap_mode_active) |-> line_cfg.line_reset_powerdown == 8'h00
      && line_cfg.tx_line_config == 8'h00 && line_cfg.rx_line_config == 8'h00)
    else $error("Line powered down or edge setting wrong.");

  a_fcs_and_fill: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_done && strap_mode_active) |-> line_cfg.tx_frame_check_control == 8'h10
      && line_cfg.tx_fill_gap_count == 8'h01)
    else $error("Check sequence or fill count wrong.");

  a_rx_fcs_straps: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_done && strap_mode_active) |-> line_cfg.rx_frame_check_control
      == {6'h04, rx_bit_lsb_first, ~descrambler_enable})
    else $error("Receive check control disagrees with straps.");

  a_max_length: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_done && strap_mode_active) |-> line_cfg.rx_line_max_length == 16'd2016
      && {mac_cfg.mac_rx_max_size_high, mac_cfg.mac_rx_max_size_low} == 16'd2016)
    else $error("Maximum frame length wrong.");

  a_mac_policy: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_done && strap_mode_active) |-> mac_cfg.tx_resend_criteria == 8'h00
      && mac_cfg.rx_reject_control == 8'h00 && mac_cfg.mac_control_word == 32'h0014000c)
    else $error("Resend, reject or MAC control default wrong.");

  // The pause time sits in the upper half of the flow control word.
  a_pause_flow: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_done && strap_mode_active) |-> mac_cfg.mac_pause_control[31:16] == 16'd320
      && mac_cfg.mac_pause_control[0] == flow_control_enable)
    else $error("Pause time or flow enable wrong.");

  a_tx_marks: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_done && strap_mode_active) |-> queue_cfg.tx_queue_high_mark == 8'h0c
      && queue_cfg.tx_queue_low_mark == 8'h06)
    else $error("Transmit watermarks wrong.");

  a_profile_queues: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_done && strap_mode_active && straps_reg.profile == 2'h2) |->
      queue_cfg.tx_queue_size == 8'h18 && queue_cfg.rx_queue_size == 8'h28
      && queue_cfg.rx_queue_low_mark == 8'h0c && queue_cfg.rx_queue_high_mark == 8'h18)
    else $error("High-rate queue codes wrong.");

  a_low_profile: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_done && strap_mode_active && straps_reg.profile == 2'h0) |->
      queue_cfg.tx_queue_size == 8'h14 && queue_cfg.rx_queue_size == 8'h2c
      && queue_cfg.rx_queue_low_mark == 8'h0f && queue_cfg.rx_queue_high_mark == 8'h1e)
    else $error("Low-rate queue codes wrong.");

  // Only 00 and 10 are defined, so a set low bit marks an undefined profile.
  a_profile_flag: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_done && strap_mode_active) |-> profile_invalid == straps_reg.profile[0])
    else $error("Undefined profile not flagged.");

  a_bit_order: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_done && strap_mode_active) |-> tx_bit_lsb_first == straps_reg.bit_order
      && laps_framing_enable == straps_reg.laps_framing)
    else $error("Bit order or framing disagrees with straps.");

  a_scrambler_pair: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_done && strap_mode_active) |-> scrambler_enable == !straps_reg.scram_bypass
      && descrambler_enable == scrambler_enable && rx_bit_lsb_first == tx_bit_lsb_first)
    else $error("Scrambler or bit order pair disagrees with straps.");

  // Outside strap mode every strap-driven enable rests low.
  a_soft_quiet: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_done && !strap_mode_active) |-> !(tx_bit_lsb_first || rx_bit_lsb_first || scrambler_enable
      || descrambler_enable || laps_framing_enable || flow_control_enable || profile_invalid))
    else $error("Strap enables active outside strap mode.");

endmodule // smdc_loader
`default_nettype wire

// ### tb/smdc_strap_board.sv
// Board model that presents the strap pins to the loader and ties the line enables high.
`timescale 1ns/1ps
`default_nettype none
module smdc_strap_board (
  input  wire smdc_pkg::smdc_straps_t setting,                // Strap levels chosen for this run.
  input  wire logic                   line_clock,             // Clock that feeds the line clock pin.
  output logic                        strap_mode_select,      // Hardware-mode strap.
  output logic [1:0]                  profile_strap,          // Line-rate profile straps.
  output logic                        auto_flow_strap,        // Flow-control strap.
  output logic                        bit_order_strap,        // Bit-order strap.
  output logic                        scrambler_bypass_strap, // Scrambler strap.
  output logic                        laps_framing_strap,     // Framing strap.
  output logic                        tx_line_enable_in,      // Transmit data enable pin.
  output logic                        rx_line_enable_in,      // Receive data enable pin.
  output logic                        tx_line_clock_in        // Transmit line clock pin.
);
  // Straps are resistor levels, so they simply follow the chosen setting.
  assign strap_mode_select      = setting.mode_select;
  assign profile_strap          = setting.profile;
  assign auto_flow_strap        = setting.auto_flow;
  assign bit_order_strap        = setting.bit_order;
  assign scrambler_bypass_strap = setting.scram_bypass;
  assign laps_framing_strap     = setting.laps_framing;
  // The enables are tied high because the device cannot gate data with them.
  assign tx_line_enable_in = 1'b1;
  assign rx_line_enable_in = 1'b1;
  // No bit times are masked here, so every edge of the line clock passes.
  assign tx_line_clock_in = line_clock;
endmodule // smdc_strap_board
`default_nettype wire

// ### tb/strap_mode_default_config_bench.sv
// Self-checking bench for the strap-mode default configuration loader.
`timescale 1ns/1ps
`default_nettype none
module strap_mode_default_config_bench;
  logic                       clk = 1'b0;          // System clock, 100 MHz.
  logic                       resetn = 1'b0;       // Reset, active low.
  smdc_pkg::smdc_straps_t     setting = '0;        // Strap levels on the board.
  logic                       sw_cfg_valid = 1'b0; // Software words valid.
  smdc_pkg::smdc_line_cfg_t   sw_line_cfg = '0;    // Software line words.
  smdc_pkg::smdc_mac_cfg_t    sw_mac_cfg = '0;     // Software MAC words.
  smdc_pkg::smdc_queue_cfg_t  sw_queue_cfg = '0;   // Software queue codes.
  smdc_pkg::smdc_line_cfg_t   line_cfg;            // Applied line words.
  smdc_pkg::smdc_mac_cfg_t    mac_cfg;             // Applied MAC words.
  smdc_pkg::smdc_queue_cfg_t  queue_cfg;           // Applied queue codes.
  wire logic [9:0]            flags;               // Level outputs, datapath release in bit 0.
  wire logic                  msel, aflow, bord, sbyp, lapf; // Strap pins.
  wire logic [1:0]            prof;                // Profile strap pins.
  int                         failures = 0;        // Mismatches seen.
  int                         check_count = 0;     // Comparisons made.

  // Free-running clock.
  always #5 clk = ~clk;

  smdc_strap_board smdc_strap_board_i (.setting(setting), .strap_mode_select(msel), .profile_strap(prof),
    .auto_flow_strap(aflow), .bit_order_strap(bord), .scrambler_bypass_strap(sbyp),
    .laps_framing_strap(lapf), .tx_line_enable_in(), .rx_line_enable_in(), .line_clock(clk),
    .tx_line_clock_in());

  smdc_loader smdc_loader_i (.clk(clk), .resetn(resetn), .strap_mode_select(msel), .profile_strap(prof),
    .auto_flow_strap(aflow), .bit_order_strap(bord), .scrambler_bypass_strap(sbyp),
    .laps_framing_strap(lapf), .sw_cfg_valid(sw_cfg_valid), .sw_line_cfg(sw_line_cfg),
    .sw_mac_cfg(sw_mac_cfg), .sw_queue_cfg(sw_queue_cfg), .line_cfg(line_cfg), .mac_cfg(mac_cfg),
    .queue_cfg(queue_cfg), .strap_mode_active(flags[9]), .tx_bit_lsb_first(flags[8]),
    .rx_bit_lsb_first(flags[7]), .scrambler_enable(flags[6]), .descrambler_enable(flags[5]),
    .laps_framing_enable(flags[4]), .flow_control_enable(flags[3]), .profile_invalid(flags[2]),
    .cfg_done(flags[1]), .datapath_resetn(flags[0]));

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Resets with the given straps and waits, bounded, for the datapath release.
  task automatic restart(input smdc_pkg::smdc_straps_t s);
    int n;
    resetn = 1'b0;
    setting = s;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    chk(96'(flags[1:0]), 96'h0);
    n = 0;
    while (flags[0] !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    // Counted from load entry, release comes after the hold count plus one in load, then one cycle in run.
    if (n == 20) begin
      failures++;
      conclude();
    end else begin
      chk(96'(n), 96'(smdc_pkg::HOLD_CYCLES) + 96'h2);
    end
  endtask

  // Loads one strap setting, checks every default, then moves the straps and checks nothing follows.
  task automatic strap_case(input smdc_pkg::smdc_straps_t s, input logic [7:0] txq, rxq, rxl, rxh,
                            input logic inv);
    logic [7:0] rxf;
    rxf = 8'h10 | {6'h0, s.bit_order, s.scram_bypass};
    restart(s);
    repeat (2) begin
      chk(96'(line_cfg), {8'h01, 8'h00, 8'h00, 8'h10, 8'h01, rxf, 16'h07e0, 8'h00});
      chk(96'(mac_cfg), {16'h0, 16'h07e0, 32'h0014000c, 32'h01400000 | {31'h0, s.auto_flow}});
      chk(96'(queue_cfg), 96'({txq, 8'h0c, 8'h06, rxq, rxl, rxh}));
      chk(96'(flags), 96'({1'b1, {2{s.bit_order}}, {2{~s.scram_bypass}}, s.laps_framing, s.auto_flow, inv,
          2'h3}));
      // Later strap movement must be ignored until the next reset.
      setting = {s.mode_select, ~s[5:0]};
      repeat (4) @(negedge clk);
    end
  endtask

  // Software mode: the straps are ignored and the software words apply.
  task automatic soft_case();
    sw_line_cfg = 72'h89_abcd_ef01_2345_6789;
    sw_mac_cfg = 96'hfedc_ba98_7654_3210_2468_ace0;
    sw_queue_cfg = 48'h1122_3344_5566;
    sw_cfg_valid = 1'b1;
    restart(7'h3f);
    chk(96'(line_cfg), 96'(sw_line_cfg));
    chk(96'(mac_cfg), 96'(sw_mac_cfg));
    chk(96'(queue_cfg), 96'(sw_queue_cfg));
    chk(96'(flags), 96'h3);
  endtask

  // Main sequence: both profiles, an undefined profile, then software mode.
  initial begin
    @(negedge clk);
    strap_case(7'h40, 8'h14, 8'h2c, 8'h0f, 8'h1e, 1'b0);
    strap_case(7'h6f, 8'h18, 8'h28, 8'h0c, 8'h18, 1'b0);
    strap_case(7'h5a, 8'h14, 8'h2c, 8'h0f, 8'h1e, 1'b1);
    soft_case();
    conclude();
  end
endmodule // strap_mode_default_config_bench
`default_nettype wire
